// ### api_pkg.sv
/*
 * Shared constants for the algorithmic phase-init sequencer: object
 * indexes, field positions, reset values, timing and the state enum.
 * Assumes a 250 MHz system clock and object-dictionary access by index.
 */
package api_pkg;

	// ************************************************************
	// object indexes
	// ************************************************************
	localparam logic [15:0] IDX_MFR_STATUS = 16'h1002;
	localparam logic [15:0] IDX_OPEN_WIRING_CUR = 16'h2142;
	localparam logic [15:0] IDX_WIRING_CHECK_TIME = 16'h2199;
	localparam logic [15:0] IDX_PHASING_MODE = 16'h21C0;
	localparam logic [15:0] IDX_PHASE_INIT_MAX_CUR = 16'h21C2;
	localparam logic [15:0] IDX_PHASE_INIT_TIME = 16'h21C3;
	localparam logic [15:0] IDX_PHASE_INIT_CONFIG = 16'h21C4;
	localparam logic [15:0] IDX_SINE_OFFSET = 16'h220B;
	localparam logic [15:0] IDX_COSINE_OFFSET = 16'h220C;
	localparam logic [15:0] IDX_COSINE_SCALE = 16'h220D;
	localparam logic [15:0] IDX_SIGNAL_MAGNITUDE = 16'h220E;
	localparam logic [15:0] IDX_MOTOR_SENSOR_CAL = 16'h2226;
	localparam logic [15:0] IDX_LOAD_SENSOR_CAL = 16'h2227;
	localparam logic [15:0] IDX_SEC_REF_OFFSET = 16'h2314;
	localparam logic [15:0] IDX_SEC_REF_CAL = 16'h2315;

	// ************************************************************
	// fields and values
	// ************************************************************
	localparam logic [15:0] MODE_ALGORITHMIC = 16'h0005;
	localparam int MFR_BUSY_BIT = 29;
	localparam int STATUS_PHASE_ERR_BIT = 6;
	localparam int CFG_FORCE_ZERO_BIT = 0;
	localparam int CFG_STEP_90_BIT = 1;
	localparam int CFG_HALL_START_BIT = 2;
	localparam logic [15:0] ANGLE_STEP_90 = 16'h4000;
	localparam logic [15:0] ANGLE_ZERO = 16'h0000;
	localparam logic [1:0] MAX_ATTEMPT_IDX = 2'h3;
	localparam int COS_SCALE_SHIFT = 15;
	localparam int MAG_SHIFT = 15;
	localparam logic [15:0] MAG_MAX = 16'h7FFF;

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [15:0] RST_PHASING_MODE = 16'h0000;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int MS_TIME = 1;
	localparam int CLK_MHZ = 250;
	localparam int CYC_PER_MS = MS_TIME * CLK_MHZ * 1000;

	typedef enum logic [2:0] {
		API_IDLE,
		API_WAIT_EN,
		API_CHECK,
		API_RUN,
		API_DONE,
		API_FAIL
	} api_state_t;

endpackage : api_pkg

// ### api_sincos.sv
/*
 * Sin/cos sensor correction: offsets, cosine amplitude scaling and the
 * squared signal magnitude. Samples arrive on the system clock from the
 * converter logic; corrected sin/cos are registered one cycle later, the magnitude one cycle after them.
 */
`timescale 1ns/1ns
`default_nettype none

module api_sincos (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic signed [15:0] sin_sample_in,
	input wire logic signed [15:0] cos_sample_in,
	input wire logic signed [15:0] sin_offset_in,
	input wire logic signed [15:0] cos_offset_in,
	input wire logic [15:0] cos_scale_in,
	output logic signed [15:0] sin_corr_out,
	output logic signed [15:0] cos_corr_out,
	output logic [15:0] magnitude_out
);

	typedef struct packed {
		logic signed [15:0] sin_c;
		logic signed [15:0] cos_c;
		logic [15:0] mag;
	} api_sc_t;

	api_sc_t sc_r;
	api_sc_t sc_nxt;

	// saturate a wide signed value to 16 bits
	function automatic logic signed [15:0] api_sat16(input logic signed [33:0] v);
		if (v > 34'sd32767) begin
			return 16'sh7FFF;
		end else if (v < -34'sd32768) begin
			return -16'sh8000;
		end
		return v[15:0];
	endfunction : api_sat16

	logic signed [33:0] sin_sum;
	logic signed [33:0] cos_sum;
	logic signed [33:0] cos_prod;
	logic [32:0] mag_sum;
	logic [32:0] mag_shift;

	always_comb begin
		sc_nxt = sc_r;
		sin_sum = 34'(sin_sample_in) + 34'(sin_offset_in);
		cos_sum = 34'(cos_sample_in) + 34'(cos_offset_in);
		cos_prod = (api_sat16(cos_sum) * $signed({18'h0, cos_scale_in})) >>> api_pkg::COS_SCALE_SHIFT;
		if (cos_scale_in == 16'h0000) begin
			sc_nxt.sin_c = sin_sample_in;
			sc_nxt.cos_c = cos_sample_in;
		end else begin
			sc_nxt.sin_c = api_sat16(sin_sum);
			sc_nxt.cos_c = api_sat16(cos_prod);
		end
		mag_sum = 33'(sc_r.sin_c * sc_r.sin_c) + 33'(sc_r.cos_c * sc_r.cos_c);
		mag_shift = mag_sum >> api_pkg::MAG_SHIFT;
		if (mag_shift > 33'(api_pkg::MAG_MAX)) begin
			sc_nxt.mag = api_pkg::MAG_MAX;
		end else begin
			sc_nxt.mag = mag_shift[15:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sc_r <= '0;
		end else begin
			sc_r <= sc_nxt;
		end
	end

	assign sin_corr_out = sc_r.sin_c;
	assign cos_corr_out = sc_r.cos_c;
	assign magnitude_out = sc_r.mag;

	a_bypass_zero: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		cos_scale_in == 16'h0000 |=> sin_corr_out == $past(sin_sample_in)
		&& cos_corr_out == $past(cos_sample_in))
		else $error("zero scale did not bypass correction");

	a_sine_offset: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		cos_scale_in != 16'h0000 && sin_sample_in == 16'sh0100 && sin_offset_in == 16'sh0010
		|=> sin_corr_out == 16'sh0110)
		else $error("sine offset not added");

endmodule : api_sincos

`default_nettype wire

// ### api_phase_init.sv
/*
 * Algorithmic phase-init sequencer with its object-dictionary registers,
 * open-wiring current check and sin/cos correction hookup.
 * Assumes enable, sensor, current and attempt signals come from logic on
 * the same 250 MHz clock; the wiggle motion itself lives outside.
 */
`timescale 1ns/1ns
`default_nettype none

module api_phase_init #(
	parameter int CYC_PER_MS = api_pkg::CYC_PER_MS
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic od_req_in,
	input wire logic od_wr_in,
	input wire logic [15:0] od_index_in,
	input wire logic [31:0] od_wdata_in,
	output logic od_ack_out,
	output logic od_err_out,
	output logic [31:0] od_rdata_out,
	input wire logic drive_enable_in,
	input wire logic signed [15:0] motor_current_in,
	input wire logic [15:0] hall_offset_in,
	input wire logic attempt_done_in,
	input wire logic attempt_ok_in,
	input wire logic signed [15:0] sin_sample_in,
	input wire logic signed [15:0] cos_sample_in,
	output logic attempt_start_out,
	output logic [15:0] attempt_angle_out,
	output logic [15:0] current_limit_out,
	output logic [15:0] current_cmd_out,
	output logic init_busy_out,
	output logic phase_err_out,
	output logic drive_disable_out,
	output logic use_encoder_out,
	output logic profile_ok_out,
	output logic motor_disc_fault_out,
	output logic signed [15:0] sin_corr_out,
	output logic signed [15:0] cos_corr_out
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		api_pkg::api_state_t state;
		api_pkg::api_state_t ret;
		logic [15:0] mode;
		logic [31:0] wire_cur;
		logic [15:0] chk_time;
		logic [15:0] max_cur;
		logic [15:0] init_time;
		logic [15:0] cfg;
		logic [15:0] sin_ofs;
		logic [15:0] cos_ofs;
		logic [15:0] cos_scale;
		logic [31:0] motor_cal;
		logic [31:0] load_cal;
		logic [15:0] sec_ofs;
		logic [15:0] sec_cal;
		logic busy;
		logic perr;
		logic dis;
		logic fault;
		logic use_enc;
		logic profile_ok;
		logic first;
		logic [1:0] attempt;
		logic [15:0] angle;
		logic start;
		logic [17:0] ms_cnt;
		logic [15:0] tmr;
		logic chk_ok;
		logic en_d;
		logic [15:0] ilim;
		logic [15:0] icmd;
		logic ack;
		logic err;
		logic [31:0] rdata;
	} api_st_t;

	api_st_t st_r;
	api_st_t st_nxt;

	logic [15:0] magnitude;
	logic en_rise;
	logic ms_tick;
	logic wr_mode;
	logic run_fail;

	localparam logic [17:0] MS_LAST = 18'(CYC_PER_MS - 1);

	function automatic logic [15:0] api_abs16(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction : api_abs16

	// ************************************************************
	// sensor correction
	// ************************************************************
	api_sincos u_sincos (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.sin_sample_in(sin_sample_in),
		.cos_sample_in(cos_sample_in),
		.sin_offset_in(st_r.sin_ofs),
		.cos_offset_in(st_r.cos_ofs),
		.cos_scale_in(st_r.cos_scale),
		.sin_corr_out(sin_corr_out),
		.cos_corr_out(cos_corr_out),
		.magnitude_out(magnitude)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		en_rise = drive_enable_in && !st_r.en_d;
		ms_tick = (st_r.ms_cnt == MS_LAST);
		wr_mode = od_req_in && od_wr_in && od_index_in == api_pkg::IDX_PHASING_MODE;
		run_fail = 1'b0;
		st_nxt.en_d = drive_enable_in;
		st_nxt.start = 1'b0;
		st_nxt.ack = od_req_in;
		st_nxt.err = 1'b0;
		st_nxt.ms_cnt = ms_tick ? 18'h0_0000 : st_r.ms_cnt + 18'h0_0001;
		if (ms_tick) begin
			st_nxt.tmr = st_r.tmr + 16'h0001;
		end

		unique case (st_r.state)
			api_pkg::API_IDLE,
			api_pkg::API_DONE: begin
				if (en_rise && st_r.chk_time != 16'h0000) begin
					st_nxt.ret = st_r.state;
					st_nxt.state = api_pkg::API_CHECK;
					st_nxt.tmr = 16'h0000;
					st_nxt.ms_cnt = 18'h0_0000;
					st_nxt.chk_ok = 1'b0;
				end
			end
			api_pkg::API_WAIT_EN: begin
				if (drive_enable_in) begin
					st_nxt.tmr = 16'h0000;
					st_nxt.ms_cnt = 18'h0_0000;
					st_nxt.chk_ok = 1'b0;
					st_nxt.ret = api_pkg::API_RUN;
					st_nxt.start = !(st_r.chk_time != 16'h0000 || st_r.cfg[api_pkg::CFG_FORCE_ZERO_BIT]);
					st_nxt.state = st_r.chk_time != 16'h0000 ? api_pkg::API_CHECK : api_pkg::API_RUN;
				end
			end
			api_pkg::API_CHECK: begin
				if (api_abs16(motor_current_in) >= st_r.wire_cur[15:0]) begin
					st_nxt.chk_ok = 1'b1;
				end
				if (st_r.ret == api_pkg::API_RUN && !drive_enable_in) begin
					st_nxt.state = api_pkg::API_WAIT_EN;
				end else if (st_r.tmr >= st_r.chk_time) begin
					if (!st_r.chk_ok) begin
						st_nxt.fault = 1'b1;
						st_nxt.dis = 1'b1;
						st_nxt.state = st_r.ret == api_pkg::API_RUN ? api_pkg::API_WAIT_EN : st_r.ret;
					end else begin
						st_nxt.state = st_r.ret;
						st_nxt.tmr = 16'h0000;
						st_nxt.ms_cnt = 18'h0_0000;
						st_nxt.start = st_r.ret == api_pkg::API_RUN
							&& !st_r.cfg[api_pkg::CFG_FORCE_ZERO_BIT];
					end
				end
			end
			api_pkg::API_RUN: begin
				if (!drive_enable_in) begin
					st_nxt.state = api_pkg::API_WAIT_EN;
				end else if (st_r.cfg[api_pkg::CFG_FORCE_ZERO_BIT]) begin
					st_nxt.angle = api_pkg::ANGLE_ZERO;
					st_nxt.state = api_pkg::API_DONE;
				end else if (attempt_done_in && attempt_ok_in) begin
					st_nxt.state = api_pkg::API_DONE;
				end else if (attempt_done_in) begin
					run_fail = 1'b1;
				end else if (st_r.init_time != 16'h0000 && st_r.tmr >= st_r.init_time) begin
					run_fail = 1'b1;
				end
				if (run_fail) begin
					st_nxt.first = 1'b0;
					if (st_r.cfg[api_pkg::CFG_STEP_90_BIT] && st_r.attempt != api_pkg::MAX_ATTEMPT_IDX) begin
						st_nxt.attempt = st_r.attempt + 2'h1;
						st_nxt.angle = st_r.angle + api_pkg::ANGLE_STEP_90;
						st_nxt.tmr = 16'h0000;
						st_nxt.ms_cnt = 18'h0_0000;
						st_nxt.start = 1'b1;
					end else begin
						st_nxt.state = api_pkg::API_FAIL;
					end
				end
			end
			api_pkg::API_FAIL: begin
			end
			default: begin
				st_nxt.state = api_pkg::API_IDLE;
			end
		endcase

		st_nxt.busy = !(st_nxt.state == api_pkg::API_IDLE || st_nxt.state == api_pkg::API_DONE
			|| (st_nxt.state == api_pkg::API_CHECK && st_nxt.ret != api_pkg::API_RUN));
		st_nxt.use_enc = st_nxt.state == api_pkg::API_DONE
			|| (st_nxt.state == api_pkg::API_CHECK && st_nxt.ret == api_pkg::API_DONE);
		if (st_nxt.state == api_pkg::API_FAIL) begin
			st_nxt.perr = 1'b1;
			st_nxt.dis = 1'b1;
		end
		st_nxt.profile_ok = st_nxt.use_enc || (st_r.mode != api_pkg::MODE_ALGORITHMIC
			&& st_nxt.state != api_pkg::API_CHECK);
		st_nxt.ilim = st_nxt.state == api_pkg::API_RUN ? st_r.max_cur
			: st_nxt.state == api_pkg::API_CHECK ? st_r.wire_cur[15:0] : 16'h0000;
		st_nxt.icmd = st_nxt.state == api_pkg::API_CHECK ? st_r.wire_cur[15:0] : 16'h0000;

		// ************************************************************
		// object dictionary access
		// ************************************************************
		st_nxt.rdata = 32'h0000_0000;
		if (od_req_in && od_wr_in) begin
			unique case (od_index_in)
				api_pkg::IDX_PHASING_MODE: st_nxt.mode = od_wdata_in[15:0];
				api_pkg::IDX_OPEN_WIRING_CUR: st_nxt.wire_cur = od_wdata_in;
				api_pkg::IDX_WIRING_CHECK_TIME: st_nxt.chk_time = od_wdata_in[15:0];
				api_pkg::IDX_PHASE_INIT_MAX_CUR: st_nxt.max_cur = od_wdata_in[15:0];
				api_pkg::IDX_PHASE_INIT_TIME: st_nxt.init_time = od_wdata_in[15:0];
				api_pkg::IDX_PHASE_INIT_CONFIG: st_nxt.cfg = od_wdata_in[15:0];
				api_pkg::IDX_SINE_OFFSET: st_nxt.sin_ofs = od_wdata_in[15:0];
				api_pkg::IDX_COSINE_OFFSET: st_nxt.cos_ofs = od_wdata_in[15:0];
				api_pkg::IDX_COSINE_SCALE: st_nxt.cos_scale = od_wdata_in[15:0];
				api_pkg::IDX_MOTOR_SENSOR_CAL: st_nxt.motor_cal = od_wdata_in;
				api_pkg::IDX_LOAD_SENSOR_CAL: st_nxt.load_cal = od_wdata_in;
				api_pkg::IDX_SEC_REF_OFFSET: st_nxt.sec_ofs = od_wdata_in[15:0];
				api_pkg::IDX_SEC_REF_CAL: st_nxt.sec_cal = od_wdata_in[15:0];
				default: st_nxt.err = 1'b1;
			endcase
		end else if (od_req_in) begin
			unique case (od_index_in)
				api_pkg::IDX_MFR_STATUS: st_nxt.rdata[api_pkg::MFR_BUSY_BIT] = st_r.busy;
				api_pkg::IDX_PHASING_MODE: st_nxt.rdata = {16'h0000, st_r.mode};
				api_pkg::IDX_OPEN_WIRING_CUR: st_nxt.rdata = st_r.wire_cur;
				api_pkg::IDX_WIRING_CHECK_TIME: st_nxt.rdata = {16'h0000, st_r.chk_time};
				api_pkg::IDX_PHASE_INIT_MAX_CUR: st_nxt.rdata = {16'h0000, st_r.max_cur};
				api_pkg::IDX_PHASE_INIT_TIME: st_nxt.rdata = {16'h0000, st_r.init_time};
				api_pkg::IDX_PHASE_INIT_CONFIG: st_nxt.rdata = {16'h0000, st_r.cfg};
				api_pkg::IDX_SINE_OFFSET: st_nxt.rdata = {16'h0000, st_r.sin_ofs};
				api_pkg::IDX_COSINE_OFFSET: st_nxt.rdata = {16'h0000, st_r.cos_ofs};
				api_pkg::IDX_COSINE_SCALE: st_nxt.rdata = {16'h0000, st_r.cos_scale};
				api_pkg::IDX_SIGNAL_MAGNITUDE: st_nxt.rdata = {16'h0000, magnitude};
				api_pkg::IDX_MOTOR_SENSOR_CAL: st_nxt.rdata = st_r.motor_cal;
				api_pkg::IDX_LOAD_SENSOR_CAL: st_nxt.rdata = st_r.load_cal;
				api_pkg::IDX_SEC_REF_OFFSET: st_nxt.rdata = {16'h0000, st_r.sec_ofs};
				api_pkg::IDX_SEC_REF_CAL: st_nxt.rdata = {16'h0000, st_r.sec_cal};
				default: st_nxt.err = 1'b1;
			endcase
		end

		// mode write overrides the sequence and clears latched errors
		if (wr_mode) begin
			st_nxt.perr = 1'b0;
			st_nxt.dis = 1'b0;
			st_nxt.fault = 1'b0;
			st_nxt.attempt = 2'h0;
			st_nxt.first = 1'b1;
			st_nxt.start = 1'b0;
			st_nxt.angle = st_r.cfg[api_pkg::CFG_HALL_START_BIT] ? hall_offset_in : api_pkg::ANGLE_ZERO;
			if (od_wdata_in[15:0] == api_pkg::MODE_ALGORITHMIC) begin
				st_nxt.state = api_pkg::API_WAIT_EN;
				st_nxt.busy = 1'b1;
				st_nxt.use_enc = 1'b0;
				st_nxt.profile_ok = 1'b0;
			end else begin
				st_nxt.state = api_pkg::API_IDLE;
				st_nxt.busy = 1'b0;
				st_nxt.use_enc = 1'b0;
				st_nxt.profile_ok = 1'b1;
			end
			st_nxt.ilim = 16'h0000;
			st_nxt.icmd = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '0;
			st_r.state <= api_pkg::API_IDLE;
			st_r.ret <= api_pkg::API_IDLE;
			st_r.mode <= api_pkg::RST_PHASING_MODE;
			st_r.profile_ok <= 1'b1;
			st_r.first <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign od_ack_out = st_r.ack;
	assign od_err_out = st_r.err;
	assign od_rdata_out = st_r.rdata;
	assign attempt_start_out = st_r.start;
	assign attempt_angle_out = st_r.angle;
	assign current_limit_out = st_r.ilim;
	assign current_cmd_out = st_r.icmd;
	assign init_busy_out = st_r.busy;
	assign phase_err_out = st_r.perr;
	assign drive_disable_out = st_r.dis;
	assign use_encoder_out = st_r.use_enc;
	assign profile_ok_out = st_r.profile_ok;
	assign motor_disc_fault_out = st_r.fault;

	// ************************************************************
	// checks
	// ************************************************************
	a_restart_sets_busy: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		wr_mode && od_wdata_in[15:0] == api_pkg::MODE_ALGORITHMIC |=> init_busy_out && !profile_ok_out)
		else $error("mode 5 write did not set busy");

	a_busy_during_run: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_WAIT_EN || st_r.state == api_pkg::API_RUN |-> init_busy_out)
		else $error("busy low while init in progress");

	a_wait_for_enable: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_WAIT_EN && !drive_enable_in && !od_req_in
		|=> st_r.state == api_pkg::API_WAIT_EN && !attempt_start_out)
		else $error("sequence left wait without enable");

	a_disable_abandons: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_RUN && !drive_enable_in && !wr_mode
		|=> st_r.state == api_pkg::API_WAIT_EN)
		else $error("disable did not abandon attempt");

	a_done_uses_enc: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_DONE |-> !init_busy_out && use_encoder_out)
		else $error("done without encoder handover");

	a_fail_flags: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_FAIL |-> init_busy_out && phase_err_out && drive_disable_out)
		else $error("failure flags missing");

	a_no_early_profile: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.mode == api_pkg::MODE_ALGORITHMIC && profile_ok_out |-> use_encoder_out)
		else $error("profile allowed before init done");

	a_force_zero: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_RUN && st_r.cfg[api_pkg::CFG_FORCE_ZERO_BIT]
		&& drive_enable_in && !od_req_in
		|=> st_r.state == api_pkg::API_DONE && attempt_angle_out == 16'h0000)
		else $error("forced zero angle not taken");

	a_angle_step: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_RUN && run_fail && !od_req_in
		&& st_r.cfg[api_pkg::CFG_STEP_90_BIT] && st_r.attempt != api_pkg::MAX_ATTEMPT_IDX
		|=> attempt_angle_out == $past(attempt_angle_out) + 16'h4000 && attempt_start_out)
		else $error("angle not stepped by a quadrant");

	a_wiring_fault: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		st_r.state == api_pkg::API_CHECK && st_r.tmr >= st_r.chk_time && !st_r.chk_ok
		&& !od_req_in && (drive_enable_in || st_r.ret != api_pkg::API_RUN)
		|=> motor_disc_fault_out && drive_disable_out)
		else $error("wiring fault not raised");

endmodule : api_phase_init

`default_nettype wire

// ### api_wiggle_model.sv
/*
 * Wiggle engine and motor stand-in for the phase-init bench.
 * Assumes the sequencer's clock and active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none

module api_wiggle_model (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic attempt_start_in,
	input wire logic [15:0] current_cmd_in,
	input wire logic pass_in,
	input wire logic wired_in,
	output logic attempt_done_out,
	output logic attempt_ok_out,
	output logic signed [15:0] motor_current_out
);
	// ************************************************************
	// attempt result, latched at start
	// ************************************************************
	int cnt;
	logic ok_r;

	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt <= 0;
			ok_r <= 1'b0;
			attempt_done_out <= 1'b0;
			attempt_ok_out <= 1'b1;
		end else begin
			attempt_done_out <= 1'b0;
			// result line is not held: shows the opposite outside done
			attempt_ok_out <= ~ok_r;
			if (attempt_start_in) begin
				cnt <= 8;
				ok_r <= pass_in;
			end else if (cnt == 1) begin
				cnt <= 0;
				attempt_done_out <= 1'b1;
				attempt_ok_out <= ok_r;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end

	assign motor_current_out = wired_in ? $signed(current_cmd_in) : 16'sh0000;

endmodule : api_wiggle_model
`default_nettype wire

// ### algorithmic_phase_init_fsm_tb_top.sv
/*
 * Self-checking bench for the phase-init sequencer over its object bus.
 * Assumes api_pkg, api_phase_init and api_wiggle_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module algorithmic_phase_init_fsm_tb_top;
	logic clk, nrst, req, wr, en, pass, wired, ack, err, e, done, ok, start;
	logic busy, perr, dis, enc, prof, fault;
	logic [15:0] idx, hall, ang, lim, cmd;
	logic [31:0] wd, rdata, rd;
	logic signed [15:0] mcur, sin_s, cos_s, sinc, cosc;
	int mismatches, n_checks;

	api_phase_init #(.CYC_PER_MS(10)) dut (.sys_clk_in(clk), .nrst_in(nrst),
		.od_req_in(req), .od_wr_in(wr), .od_index_in(idx), .od_wdata_in(wd),
		.od_ack_out(ack), .od_err_out(err), .od_rdata_out(rdata),
		.drive_enable_in(en), .motor_current_in(mcur), .hall_offset_in(hall),
		.attempt_done_in(done), .attempt_ok_in(ok), .sin_sample_in(sin_s),
		.cos_sample_in(cos_s), .attempt_start_out(start), .attempt_angle_out(ang),
		.current_limit_out(lim), .current_cmd_out(cmd), .init_busy_out(busy),
		.phase_err_out(perr), .drive_disable_out(dis), .use_encoder_out(enc),
		.profile_ok_out(prof), .motor_disc_fault_out(fault),
		.sin_corr_out(sinc), .cos_corr_out(cosc));

	api_wiggle_model far_end (.sys_clk_in(clk), .nrst_in(nrst),
		.attempt_start_in(start), .current_cmd_in(cmd), .pass_in(pass),
		.wired_in(wired), .attempt_done_out(done), .attempt_ok_out(ok),
		.motor_current_out(mcur));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, s, x);
		end
	endtask : chk

	task automatic wrap_up;
		if (mismatches == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	// one access, entered at a falling edge; answer is a single-cycle pulse
	task automatic od(input logic w, input logic [15:0] i, input logic [31:0] d);
		int k;
		req = 1'b1;
		wr = w;
		idx = i;
		wd = d;
		@(negedge clk);
		req = 1'b0;
		for (k = 0; k < 4 && ack !== 1'b1; k++) @(negedge clk);
		if (ack !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: no answer", $time);
			wrap_up();
		end
		rd = rdata;
		e = err;
		// gap cycle: the next access must not raise req in this time step
		@(negedge clk);
	endtask : od

	task automatic wo(input logic [15:0] i, input logic [31:0] d);
		od(1'b1, i, d);
		chk(e, 1'b0);
	endtask : wo

	function automatic logic ev(input int s);
		case (s)
			0: ev = start;
			1: ev = !busy;
			2: ev = perr;
			default: ev = fault;
		endcase
	endfunction : ev

	task automatic wev(input int s);
		int k;
		for (k = 0; k < 300 && ev(s) !== 1'b1; k++) @(negedge clk);
		if (ev(s) !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: event never seen", $time);
			wrap_up();
		end
	endtask : wev

	task automatic rerun(input logic [15:0] cfg);
		en = 1'b0;
		wo(api_pkg::IDX_PHASE_INIT_CONFIG, {16'h0000, cfg});
		wo(api_pkg::IDX_PHASING_MODE, 32'h0000_0005);
		en = 1'b1;
	endtask : rerun

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		{nrst, req, wr, idx, wd, en, sin_s, cos_s, pass} = '0;
		{mismatches, n_checks} = '0;
		hall = 16'h1234;
		wired = 1'b1;
		repeat (4) @(negedge clk);
		chk(prof, 1'b1);
		nrst = 1'b1;
		@(negedge clk);
		od(1'b0, 16'h3000, 32'h0000_0000);
		chk(e, 1'b1);
		od(1'b1, api_pkg::IDX_SIGNAL_MAGNITUDE, 32'h0000_0001);
		chk(e, 1'b1);
		od(1'b0, api_pkg::IDX_PHASE_INIT_CONFIG, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wo(api_pkg::IDX_SINE_OFFSET, 32'h0000_0010);
		wo(api_pkg::IDX_COSINE_OFFSET, 32'h0000_FFE0);
		sin_s = 16'sh0100;
		cos_s = 16'sh0100;
		repeat (2) @(negedge clk);
		chk(sinc, 32'h0000_0100);
		chk(cosc, 32'h0000_0100);
		wo(api_pkg::IDX_COSINE_SCALE, 32'h0000_4000);
		repeat (2) @(negedge clk);
		chk(sinc, 32'h0000_0110);
		chk(cosc, 32'h0000_0070);
		od(1'b0, api_pkg::IDX_SIGNAL_MAGNITUDE, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		wo(api_pkg::IDX_PHASE_INIT_MAX_CUR, 32'h0000_0123);
		wo(api_pkg::IDX_PHASE_INIT_CONFIG, 32'h0000_0000);
		wo(api_pkg::IDX_PHASING_MODE, 32'h0000_0005);
		chk(busy, 1'b1);
		od(1'b0, api_pkg::IDX_MFR_STATUS, 32'h0000_0000);
		chk(rd, 32'h2000_0000);
		chk(prof, 1'b0);
		repeat (6) @(negedge clk);
		chk(enc, 1'b0);
		pass = 1'b1;
		en = 1'b1;
		wev(0);
		chk(lim, 32'h0000_0123);
		wev(1);
		chk({enc, prof}, 2'b11);
		od(1'b0, api_pkg::IDX_MFR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		pass = 1'b0;
		rerun(16'h0000);
		wev(2);
		chk({busy, dis}, 2'b11);
		rerun(16'h0002);
		wev(0);
		chk(ang, 32'h0000_0000);
		// result is latched on the edge after start: first attempt must fail
		@(negedge clk);
		pass = 1'b1;
		wev(0);
		chk(ang, 32'h0000_4000);
		en = 1'b0;
		repeat (12) @(negedge clk);
		chk(busy, 1'b1);
		en = 1'b1;
		wev(0);
		wev(1);
		rerun(16'h0004);
		wev(0);
		chk(ang, 32'h0000_1234);
		wev(1);
		// hall start set too, so a zero angle proves the force
		rerun(16'h0005);
		wev(1);
		chk(ang, 32'h0000_0000);
		wired = 1'b0;
		wo(api_pkg::IDX_WIRING_CHECK_TIME, 32'h0000_0002);
		wo(api_pkg::IDX_OPEN_WIRING_CUR, 32'h0000_0050);
		rerun(16'h0000);
		repeat (2) @(negedge clk);
		chk(cmd, 32'h0000_0050);
		wev(3);
		chk(dis, 1'b1);
		wired = 1'b1;
		rerun(16'h0000);
		wev(0);
		chk(fault, 1'b0);
		wrap_up();
	end

endmodule : algorithmic_phase_init_fsm_tb_top
`default_nettype wire
